// File: hfrc_hold_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hfrc_hold_sync #(
  parameter int W = 10
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] synced
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      synced <= '0;
    end else if (s2_q == s3_q) begin
      synced <= s3_q;
    end
  end

  AST_SYNC_MATCH: assert property (@(posedge mclk) disable iff (!reset_n)
    !$stable(synced) |-> $past(s2_q) == $past(s3_q) && synced == $past(s3_q))
    else $error("holdover copy changed without two equal samples");
endmodule
`default_nettype wire

// File: hfrc_pkg.sv
`default_nettype none
package hfrc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] HFRC_ADDR_ALIGN_WIN   = 8'h15;
  localparam logic [7:0] HFRC_ADDR_HOLD_HIGH   = 8'h16;
  localparam logic [7:0] HFRC_ADDR_HOLD_LOW    = 8'h17;
  localparam logic [7:0] HFRC_ADDR_FREE_HIGH   = 8'h18;
  localparam logic [7:0] HFRC_ADDR_FREE_LOW    = 8'h19;
  localparam logic [7:0] HFRC_ADDR_CONV_DIS    = 8'h1A;

  // ==========================================================
  // Field layout and reset values
  localparam int         HFRC_WIN_W            = 3;
  localparam int         HFRC_VOLT_W           = 10;
  localparam int         HFRC_ADC_DIS_BIT      = 1;
  localparam int         HFRC_DAC_DIS_BIT      = 0;
  localparam logic [2:0] HFRC_WIN_RST          = 3'h2;
  localparam logic [1:0] HFRC_FREE_HIGH_RST    = 2'h1;
  localparam logic [7:0] HFRC_FREE_LOW_RST     = 8'hFF;
  localparam logic [7:0] HFRC_HOLD_LOW_RST     = 8'h00;
  localparam logic       HFRC_DIS_RST          = 1'b0;

  // ==========================================================
  // Alignment counter: must reach 2^7
  localparam int         HFRC_CNT_W            = 9;

  typedef enum logic [1:0] {
    HFRC_AL_IDLE     = 2'b00,
    HFRC_AL_WAIT_VS  = 2'b01,
    HFRC_AL_WAIT_TOF = 2'b10
  } hfrc_align_e;
endpackage
`default_nettype wire

// File: hfrc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hfrc_regs (
  input  wire logic                              mclk,
  input  wire logic                              reset_n,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [7:0]                        reg_wdata,
  output logic      [7:0]                        reg_rdata,
  input  wire logic                              primary_frame_pulse,
  input  wire logic                              vsync,
  output logic                                   alignment_loss,
  input  wire logic [hfrc_pkg::HFRC_VOLT_W-1:0]  holdover_voltage,
  input  wire logic                              freerun_mode,
  output logic      [hfrc_pkg::HFRC_VOLT_W-1:0]  loop_filter_control_pin,
  output logic                                   holdover_adc_disable,
  output logic                                   dac_disable
);
  import hfrc_pkg::*;

  // ==========================================================
  // Register state
  logic [HFRC_WIN_W-1:0]   win_q;
  logic [1:0]              freerun_high_q;
  logic [7:0]              freerun_low_q;
  logic [HFRC_VOLT_W-1:0]  freerun_voltage;
  logic [7:0]              hold_low_latch_q;
  logic                    adc_dis_q;
  logic                    dac_dis_q;
  logic [HFRC_VOLT_W-1:0]  holdover_voltage_synced;

  logic wr_win;
  logic wr_free_high;
  logic wr_free_low;
  logic wr_conv;
  logic rd_hold_high;
  logic rd_hold_low;

  assign wr_win       = reg_wr && (reg_addr == HFRC_ADDR_ALIGN_WIN);
  assign wr_free_high = reg_wr && (reg_addr == HFRC_ADDR_FREE_HIGH);
  assign wr_free_low  = reg_wr && (reg_addr == HFRC_ADDR_FREE_LOW);
  assign wr_conv      = reg_wr && (reg_addr == HFRC_ADDR_CONV_DIS);
  assign rd_hold_high = reg_rd && (reg_addr == HFRC_ADDR_HOLD_HIGH);
  assign rd_hold_low  = reg_rd && (reg_addr == HFRC_ADDR_HOLD_LOW);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      win_q <= HFRC_WIN_RST;
    end else if (wr_win) begin
      win_q <= reg_wdata[HFRC_WIN_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      freerun_high_q <= HFRC_FREE_HIGH_RST;
    end else if (wr_free_high) begin
      freerun_high_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      freerun_low_q <= HFRC_FREE_LOW_RST;
    end else if (wr_free_low) begin
      freerun_low_q <= reg_wdata;
    end
  end

  // Split halves so each write strobe owns one register
  assign freerun_voltage = {freerun_high_q, freerun_low_q};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adc_dis_q <= HFRC_DIS_RST;
      dac_dis_q <= HFRC_DIS_RST;
    end else if (wr_conv) begin
      adc_dis_q <= reg_wdata[HFRC_ADC_DIS_BIT];
      dac_dis_q <= reg_wdata[HFRC_DAC_DIS_BIT];
    end
  end

  assign holdover_adc_disable = adc_dis_q;
  assign dac_disable          = dac_dis_q;

  // ==========================================================
  // Holdover voltage capture
  hfrc_hold_sync #(
    .W (HFRC_VOLT_W)
  ) u_hold_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .raw_in  (holdover_voltage),
    .synced  (holdover_voltage_synced)
  );

  // snapshot low byte on high read
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hold_low_latch_q <= HFRC_HOLD_LOW_RST;
    end else if (rd_hold_high) begin
      hold_low_latch_q <= holdover_voltage_synced[7:0];
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        HFRC_ADDR_ALIGN_WIN: reg_rdata <= {5'h00, win_q};
        HFRC_ADDR_HOLD_HIGH: reg_rdata <= {6'h00, holdover_voltage_synced[9:8]};
        HFRC_ADDR_HOLD_LOW:  reg_rdata <= hold_low_latch_q;
        HFRC_ADDR_FREE_HIGH: reg_rdata <= {6'h00, freerun_high_q};
        HFRC_ADDR_FREE_LOW:  reg_rdata <= freerun_low_q;
        HFRC_ADDR_CONV_DIS:  reg_rdata <= {6'h00, adc_dis_q, dac_dis_q};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Loop-filter drive
  // Outside free-run the captured holdover value is held on the pin
  // free-run drives the setting
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      loop_filter_control_pin <= {HFRC_FREE_HIGH_RST, HFRC_FREE_LOW_RST};
    end else if (freerun_mode) begin
      loop_filter_control_pin <= freerun_voltage;
    end else begin
      loop_filter_control_pin <= holdover_voltage_synced;
    end
  end

  // ==========================================================
  // Frame pulse inputs: three stages, accept on agreement
  logic [1:0] p1_q;
  logic [1:0] p2_q;
  logic [1:0] p3_q;
  logic [1:0] lvl_q;
  logic [1:0] lvl_prev_q;
  logic       tof_evt;
  logic       vs_evt;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      p1_q <= 2'h0;
      p2_q <= 2'h0;
      p3_q <= 2'h0;
    end else begin
      p1_q <= {vsync, primary_frame_pulse};
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lvl_q      <= 2'h0;
      lvl_prev_q <= 2'h0;
    end else begin
      lvl_q      <= (p2_q & p3_q) | (lvl_q & (p2_q | p3_q));
      lvl_prev_q <= lvl_q;
    end
  end

  assign tof_evt = lvl_q[0] && !lvl_prev_q[0];
  assign vs_evt  = lvl_q[1] && !lvl_prev_q[1];

  // ==========================================================
  // Alignment window check
  function automatic logic [HFRC_CNT_W-1:0] win_limit(input logic [HFRC_WIN_W-1:0] n);
    win_limit = HFRC_CNT_W'(1) << n;
  endfunction

  hfrc_align_e             al_state_q;
  logic [HFRC_CNT_W-1:0]   al_cnt_q;
  logic [HFRC_CNT_W-1:0]   al_limit;
  logic                    partner_evt;

  assign al_limit    = win_limit(win_q);
  assign partner_evt = (al_state_q == HFRC_AL_WAIT_VS) ? vs_evt : tof_evt;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      al_state_q     <= HFRC_AL_IDLE;
      al_cnt_q       <= '0;
      alignment_loss <= 1'b0;
    end else begin
      case (al_state_q)
        HFRC_AL_IDLE: begin
          al_cnt_q <= HFRC_CNT_W'(1);
          if (tof_evt && vs_evt) begin
            alignment_loss <= 1'b0;
          end else if (tof_evt) begin
            al_state_q <= HFRC_AL_WAIT_VS;
          end else if (vs_evt) begin
            al_state_q <= HFRC_AL_WAIT_TOF;
          end
        end
        HFRC_AL_WAIT_VS, HFRC_AL_WAIT_TOF: begin
          if (partner_evt) begin
            alignment_loss <= 1'b0;
            al_state_q     <= HFRC_AL_IDLE;
          end else if (al_cnt_q >= al_limit) begin
            alignment_loss <= 1'b1;
            al_state_q     <= HFRC_AL_IDLE;
          end else begin
            al_cnt_q <= al_cnt_q + HFRC_CNT_W'(1);
          end
        end
        default: begin
          al_state_q <= HFRC_AL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  AST_LOA_SET: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(alignment_loss) |-> $past(al_cnt_q) == $past(al_limit) && $past(al_state_q) != HFRC_AL_IDLE)
    else $error("alignment loss raised at wrong offset");

  AST_LOA_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
    (al_state_q != HFRC_AL_IDLE && partner_evt) |=> !alignment_loss)
    else $error("alignment loss not cleared on matched pulse");

  AST_HOLD_HIGH_READ: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_hold_high |=> reg_rdata == {6'h00, $past(holdover_voltage_synced[9:8])}
      && hold_low_latch_q == $past(holdover_voltage_synced[7:0]))
    else $error("holdover high read or low snapshot wrong");

  AST_HOLD_LOW_READ: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_hold_high ##1 (!rd_hold_high)[*2] ##0 rd_hold_low |=> reg_rdata == $past(hold_low_latch_q, 1))
    else $error("holdover low read not the snapshot");

  AST_FREERUN_DRIVE: assert property (@(posedge mclk) disable iff (!reset_n)
    freerun_mode ##1 freerun_mode |-> loop_filter_control_pin == $past(freerun_voltage))
    else $error("loop filter pin not the free-run setting");

  AST_FREE_HIGH_WR: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_free_high |=> freerun_high_q == $past(reg_wdata[1:0])
      && freerun_low_q == $past(freerun_low_q))
    else $error("free-run high write wrong");

  AST_FREE_LOW_WR: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_free_low |=> freerun_low_q == $past(reg_wdata)
      && freerun_high_q == $past(freerun_high_q))
    else $error("free-run low write wrong");

  AST_ADC_DIS: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_conv |=> holdover_adc_disable == $past(reg_wdata[HFRC_ADC_DIS_BIT]))
    else $error("ADC disable output not following write");

  AST_DAC_DIS: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_conv |=> dac_disable == $past(reg_wdata[HFRC_DAC_DIS_BIT]))
    else $error("DAC disable output not following write");

  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd && reg_addr == HFRC_ADDR_ALIGN_WIN) |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(win_q))
    else $error("window register readback wrong");

  AST_ALIGN_SIMUL: assert property (@(posedge mclk) disable iff (!reset_n)
    (al_state_q == HFRC_AL_IDLE && tof_evt && vs_evt) |=> !alignment_loss)
    else $error("simultaneous pulses not judged aligned");

  AST_HOLD_LOW_ANY: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_hold_low |=> reg_rdata == $past(hold_low_latch_q))
    else $error("holdover low read not the latched byte");

  AST_RDATA_STANDS: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");

  AST_CONV_RSVD: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd && reg_addr == HFRC_ADDR_CONV_DIS) |=> reg_rdata[7:2] == 6'h00)
    else $error("disable register reserved bits not zero");
endmodule
`default_nettype wire

// File: test_holdover_freerun_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_holdover_freerun_control_regs;
  import hfrc_pkg::*;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       primary_frame_pulse = 1'b0;
  logic       vsync = 1'b0;
  logic       alignment_loss;
  logic [9:0] holdover_voltage = 10'h000;
  logic       freerun_mode = 1'b1;
  logic [9:0] loop_filter_control_pin;
  logic       holdover_adc_disable;
  logic       dac_disable;
  int         num_errors = 0;
  int         tests_run = 0;
  integer     seed = 32'hd6e7;
  int         win_m;
  int         fhi_m;
  int         flo_m;
  int         dis_m;
  int         cnt;
  logic [31:0] a;
  logic [31:0] b;

  always #5 mclk = ~mclk;

  hfrc_regs dut_u (
    .mclk                    (mclk),
    .reset_n                 (reset_n),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .primary_frame_pulse     (primary_frame_pulse),
    .vsync                   (vsync),
    .alignment_loss          (alignment_loss),
    .holdover_voltage        (holdover_voltage),
    .freerun_mode            (freerun_mode),
    .loop_filter_control_pin (loop_filter_control_pin),
    .holdover_adc_disable    (holdover_adc_disable),
    .dac_disable             (dac_disable)
  );

  // ==========================================================
  // Reporting
  task automatic summarize();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_out(input string nm, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // Register bus
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Data is registered, so it is sampled after the next edge settles
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk_reg($sformatf("reg_%h", ad), e, reg_rdata);
  endtask

  // Four-cycle pulses at given offsets; a negative offset leaves one out
  task automatic frames(input int t_at, input int v_at, input int len);
    for (int k = 0; k < len; k++) begin
      @(posedge mclk);
      primary_frame_pulse <= (t_at >= 0) && (k >= t_at) && (k < t_at + 4);
      vsync <= (v_at >= 0) && (k >= v_at) && (k < v_at + 4);
    end
    #1;
  endtask

  task automatic chk_pins();
    #1;
    chk_out("loop_pin", 10'((fhi_m << 8) | flo_m), loop_filter_control_pin);
    chk_out("adc_dis", 10'(dis_m >> 1), 10'(holdover_adc_disable));
    chk_out("dac_dis", 10'(dis_m & 1), 10'(dac_disable));
  endtask

  // Caller stands on a rising edge; model returns to reset values
  task automatic reset_chk();
    reset_n <= 1'b0;
    freerun_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    win_m = HFRC_WIN_RST;
    fhi_m = HFRC_FREE_HIGH_RST;
    flo_m = HFRC_FREE_LOW_RST;
    dis_m = 0;
    @(posedge mclk);
    chk_pins();
    chk_out("loss_reset", 10'h000, 10'(alignment_loss));
    rd_chk(HFRC_ADDR_ALIGN_WIN, 8'(win_m));
    rd_chk(HFRC_ADDR_FREE_HIGH, 8'(fhi_m));
    rd_chk(HFRC_ADDR_FREE_LOW, 8'(flo_m));
    rd_chk(HFRC_ADDR_CONV_DIS, 8'(dis_m));
    rd_chk(HFRC_ADDR_HOLD_LOW, HFRC_HOLD_LOW_RST);
    rd_chk(8'h3C, 8'h00);
  endtask

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  initial begin
    reset_chk();
    // Random settings with random reserved bits; read-only writes dropped
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      wr(HFRC_ADDR_FREE_HIGH, a[7:0]);
      wr(HFRC_ADDR_FREE_LOW, a[15:8]);
      wr(HFRC_ADDR_CONV_DIS, a[23:16]);
      wr(HFRC_ADDR_HOLD_HIGH, 8'hFF);
      wr(HFRC_ADDR_HOLD_LOW, 8'hFF);
      wr(8'h1B, 8'hFF);
      fhi_m = a[1:0];
      flo_m = a[15:8];
      dis_m = a[17:16];
      rd_chk(HFRC_ADDR_FREE_HIGH, 8'(fhi_m));
      rd_chk(HFRC_ADDR_FREE_LOW, 8'(flo_m));
      rd_chk(HFRC_ADDR_CONV_DIS, 8'(dis_m));
      rd_chk(HFRC_ADDR_HOLD_HIGH, 8'h00);
      rd_chk(HFRC_ADDR_HOLD_LOW, 8'h00);
      chk_pins();
    end
    // Holdover snapshot stays coherent while the input moves on
    @(posedge mclk);
    freerun_mode <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      b = $random(seed);
      @(posedge mclk);
      holdover_voltage <= a[9:0];
      repeat (6) @(posedge mclk);
      rd_chk(HFRC_ADDR_HOLD_HIGH, {6'h00, a[9:8]});
      @(posedge mclk);
      holdover_voltage <= b[9:0];
      repeat (6) @(posedge mclk);
      rd_chk(HFRC_ADDR_HOLD_LOW, a[7:0]);
      // Unequal successive samples must never reach the synced copy
      for (int k = 0; k < 12; k++) begin
        @(posedge mclk);
        holdover_voltage <= (k % 2 == 0) ? ~b[9:0] : b[9:0];
      end
      #1;
      chk_out("hold_pin", b[9:0], loop_filter_control_pin);
    end
    // Window codes: offset of exactly 2^n is aligned, a lone pulse is not
    for (int n = 0; n < 8; n++) begin
      a = $random(seed);
      wr(HFRC_ADDR_ALIGN_WIN, {a[7:3], 3'(n)});
      rd_chk(HFRC_ADDR_ALIGN_WIN, 8'(n));
      if (n % 2 == 1) begin
        frames(1 << n, 0, (1 << n) + 24);
      end else begin
        frames(0, 1 << n, (1 << n) + 24);
      end
      chk_out("loss_aligned", 10'h000, 10'(alignment_loss));
      // Lone pulse of either kind, so both waiting states time out
      if (n % 2 == 1) begin
        frames(-1, 0, 6);
      end else begin
        frames(0, -1, 6);
      end
      cnt = 5;
      while (alignment_loss !== 1'b1 && cnt < (1 << n) + 12) begin
        @(posedge mclk);
        #1;
        cnt++;
      end
      chk_out("loss_delay_ok", 10'h001, 10'(cnt >= (1 << n) + 3 && cnt <= (1 << n) + 7));
      frames(0, 0, 24);
      chk_out("loss_cleared", 10'h000, 10'(alignment_loss));
    end
    // Mid-run reset with a loss standing and every register moved
    wr(HFRC_ADDR_ALIGN_WIN, 8'h00);
    frames(0, -1, 12);
    chk_out("loss_lone", 10'h001, 10'(alignment_loss));
    @(posedge mclk);
    reset_chk();
    summarize();
  end
endmodule
`default_nettype wire
